// [core/ieipc_pkg.sv]
/*
 ieipc_pkg: constants, register map, field layout and carrier types of the
 input edge interrupt and pulse capture block.
 Assumes a 10 MHz system clock and a plain register port with 32-bit data.
*/
// Contract
// - A line set for interrupt use requests its routine on its selected edge.
// - Default map is line n to vector n with priority n plus 5.
// - Priorities 1 to 4 belong to timer vectors 28 to 31, never lines.
// - Vectors relocate by start vector, count, start input and start sequence number.
// - Empty relocated range or interrupt lines outside it raise parameter error 3000.
// - Each line triggers on rising, falling or both edges, only as selected.
// - While a routine runs, one further trigger is held, later ones dropped.
// - Unlock enables, lockout disables all, per-program mask blocks single routines.
// - Each line is filtered with a selectable response time per line type.
// - A standard line at 0.1 ms still needs 0.2 ms for on-to-off.
// - Pulse capture registers pulses shorter than one program scan.
// - A captured pulse sets the input bit for one scan, cleared at scan end.
// - Capture triggers on the rising edge of the filtered input.
// - Several pulses in one scan register only the first.
// - Pulses in successive scans give as many scans of on.
// - A pulse spanning several scans still gives one scan of on.
// - Immediate-read or partial-refresh access to a capture line is unsupported.
package ieipc_pkg;
   localparam int NL = 16;
   localparam int LW = 4;
   localparam int N_FAST = 6;
   localparam int CLK_NS = 100;
   localparam int TICK_NS = 10000; // Filter time base of 10 us
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int CNT_W = 13;
   localparam logic [2:0] SEL_MAX = 3'h5;
   localparam logic [4:0] PRIO_BASE = 5'h05;
   localparam logic [4:0] PRIO_TIMER_MAX = 5'h04;
   localparam logic [15:0] ERR_PARAM = 16'h0BB8; // Code 3000
   // Register offsets
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_FUNC = 8'h04;
   localparam logic [7:0] A_EDGE = 8'h08;
   localparam logic [7:0] A_MASK = 8'h0C;
   localparam logic [7:0] A_RESP0 = 8'h10;
   localparam logic [7:0] A_RESP1 = 8'h14;
   localparam logic [7:0] A_VEC = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1C;
   localparam logic [7:0] A_PEND = 8'h20;
   localparam logic [7:0] A_BITS = 8'h24;
   localparam logic [7:0] A_LVL = 8'h28;
   // Field positions
   localparam int CMD_UNLOCK = 0;
   localparam int CMD_LOCK = 1;
   localparam int ST_ERR = 0;
   localparam int ST_UNSUP = 1;
   localparam int ED_RISE = 0;
   localparam int ED_FALL = 1;
   localparam int RESP_FW = 4;
   // Reset values
   localparam logic [31:0] RST_FUNC = 32'h0000_0000;
   localparam logic [31:0] RST_EDGE = 32'h5555_5555; // Rising edge on all lines
   localparam logic [31:0] RST_RESP = 32'h0000_0000;
   localparam logic [31:0] RST_VEC = 32'h0000_0000;
   // Response times in microseconds, indexed by the line's selection code
   localparam int STD_US [6] = '{100, 1000, 5000, 10000, 20000, 70000};
   localparam int FAST_US [6] = '{10, 100, 200, 400, 600, 1000};
   localparam int STD_OFF_MIN_US = 200;

   // Least time rounds up to whole filter ticks
   function automatic logic [CNT_W-1:0] us_to_ticks(input int us);
      return CNT_W'((us * 1000 + TICK_NS - 1) / TICK_NS);
   endfunction

   typedef struct packed {
      logic reloc;
      logic [2:0] rsv;
      logic [7:0] start_si;
      logic [3:0] start_in;
      logic [7:0] count;
      logic [7:0] start_vec;
   } ieipc_vcfg_s;

   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      logic [4:0] prio;
      logic [3:0] line;
      logic [7:0] seq;
   } ieipc_irq_s;
endpackage

// [core/ieipc_filter.sv]
/*
 ieipc_filter: one input line's response-time filter.
 Assumes a one-cycle tick enable every filter time base and a raw input
 already synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ieipc_filter import ieipc_pkg::*; #(
   parameter bit FAST = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic raw,
   input wire logic [2:0] sel,
   output logic lvl
);
   logic [CNT_W-1:0] cnt_ff;
   logic lvl_ff;
   logic [2:0] idx;
   logic [CNT_W-1:0] lim;
   logic diff;
   logic done;

   ////////////////////////////////////////////////////////////////////////
   // Limit lookup; codes above the table take its slowest entry
   always_comb begin
      idx = (sel > SEL_MAX) ? SEL_MAX : sel;
      lim = FAST ? us_to_ticks(FAST_US[idx]) : us_to_ticks(STD_US[idx]);
      // Standard input stage cannot release faster than 0.2 ms
      if (!FAST && idx == 3'h0 && lvl_ff) begin
         lim = us_to_ticks(STD_OFF_MIN_US);
      end
   end

   assign diff = raw != lvl_ff;
   assign done = tick && diff && ((cnt_ff + CNT_W'(1)) >= lim);
   assign lvl = lvl_ff;

   ////////////////////////////////////////////////////////////////////////
   // Level must differ for the whole time; any bounce restarts the count
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         lvl_ff <= 1'b0;
      end else begin
         if (!diff || done) begin
            cnt_ff <= '0;
         end else if (tick) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
         end
         if (done) begin
            lvl_ff <= raw;
         end
      end
   end

   flt_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(lvl_ff) |-> $past(tick) && $past(raw) == lvl_ff)
      else $error("Filter level moved without a tick");
endmodule
`default_nettype wire

// [core/ieipc_top.sv]
/*
 ieipc_top: edge interrupt requester and pulse stretcher on sixteen
 filtered input lines, with a small register file.
 Assumes inputs synchronous to clock, a one-cycle scan_end pulse from the
 scan logic, and an execution unit that takes and ends routines.
*/
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ieipc_top import ieipc_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [NL-1:0] ext_in,
   input wire logic scan_end,
   input wire logic irq_take,
   input wire logic irq_end,
   input wire logic [LW-1:0] end_line,
   input wire logic direct_access,
   input wire logic [LW-1:0] access_line,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output ieipc_irq_s irq,
   output logic [NL-1:0] input_bits
);
   logic [15:0] div_ff;
   logic gen_ff;
   logic [31:0] func_ff;
   logic [31:0] edge_ff;
   logic [NL-1:0] mask_ff;
   logic [31:0] resp0_ff;
   logic [31:0] resp1_ff;
   ieipc_vcfg_s vec_ff;
   logic err_ff;
   logic unsup_ff;
   logic [31:0] rdata_ff;
   logic [NL-1:0] prev_ff;
   logic [NL-1:0] pend_ff;
   logic [NL-1:0] busy_ff;
   logic [NL-1:0] latch_ff;
   logic [NL-1:0] bits_ff;
   ieipc_irq_s irq_ff;
   ieipc_irq_s nxt_irq;
   logic [LW-1:0] win;
   logic found;

   ////////////////////////////////////////////////////////////////////////
   // Filter time base: the only slower rate, as a one-cycle enable
   wire tick = (div_ff == 16'(TICK_CYCLES - 1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= '0;
      end else begin
         div_ff <= tick ? '0 : div_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_cmd = wr && addr == A_CMD;
   wire wr_func = wr && addr == A_FUNC;
   wire wr_edge = wr && addr == A_EDGE;
   wire wr_mask = wr && addr == A_MASK;
   wire wr_resp0 = wr && addr == A_RESP0;
   wire wr_resp1 = wr && addr == A_RESP1;
   wire wr_vec = wr && addr == A_VEC;
   wire wr_stat = wr && addr == A_STAT;

   // Line function: interrupt wins where both bits are set
   wire [NL-1:0] int_sel = func_ff[NL-1:0];
   wire [NL-1:0] pc_sel = func_ff[2*NL-1:NL] & ~int_sel;
   wire [63:0] resp_all = {resp1_ff, resp0_ff};

   ////////////////////////////////////////////////////////////////////////
   // Software-written configuration
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         func_ff <= RST_FUNC;
         edge_ff <= RST_EDGE;
         mask_ff <= '0;
         resp0_ff <= RST_RESP;
         resp1_ff <= RST_RESP;
         vec_ff <= RST_VEC;
      end else begin
         if (wr_func) func_ff <= wdata;
         if (wr_edge) edge_ff <= wdata;
         if (wr_mask) mask_ff <= wdata[NL-1:0];
         if (wr_resp0) resp0_ff <= wdata;
         if (wr_resp1) resp1_ff <= wdata;
         if (wr_vec) vec_ff <= wdata;
      end
   end

   // Global unlock and lockout; lockout wins when both bits are written
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gen_ff <= 1'b0;
      end else if (wr_cmd && wdata[CMD_LOCK]) begin
         gen_ff <= 1'b0;
      end else if (wr_cmd && wdata[CMD_UNLOCK]) begin
         gen_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-line filter, edge selection and relocation range
   logic [NL-1:0] lvl;
   logic [NL-1:0] trig;
   logic [NL-1:0] in_rng;
   wire [NL-1:0] rise = lvl & ~prev_ff;
   wire [NL-1:0] fall = ~lvl & prev_ff;

   for (genvar gi = 0; gi < NL; gi++) begin : g_line
      wire [8:0] lo = {5'h00, vec_ff.start_in};
      wire [8:0] hi = lo + {1'b0, vec_ff.count};
      ieipc_filter #(.FAST(gi < N_FAST)) u_flt (
         .clock(clock),
         .rst_n(rst_n),
         .tick(tick),
         .raw(ext_in[gi]),
         .sel(resp_all[gi*RESP_FW +: 3]),
         .lvl(lvl[gi])
      );
      // Only the selected edges count
      assign trig[gi] = int_sel[gi] && ((rise[gi] && edge_ff[2*gi+ED_RISE]) ||
         (fall[gi] && edge_ff[2*gi+ED_FALL]));
      assign in_rng[gi] = 9'(gi) >= lo && 9'(gi) < hi;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parameter check: relocated range must hold all interrupt lines, and at least one
   wire err_w = vec_ff.reloc && ((int_sel & in_rng) == '0 ||
      (int_sel & ~in_rng) != '0);
   wire [NL-1:0] map_ok = vec_ff.reloc ? in_rng : '1;

   ////////////////////////////////////////////////////////////////////////
   // Pending and running routines
   wire took = irq_ff.valid && irq_take;
   wire [NL-1:0] take_oh = took ? (NL'(1) << irq_ff.line) : '0;
   wire [NL-1:0] end_oh = irq_end ? (NL'(1) << end_line) : '0;
   // A held trigger is one bit: a second while set is simply lost
   wire [NL-1:0] nxt_pend = (trig | (pend_ff & ~take_oh)) & int_sel;
   // Start wins over end when both hit one line
   wire [NL-1:0] nxt_busy = take_oh | (busy_ff & ~end_oh);
   wire [NL-1:0] elig = pend_ff & ~busy_ff & ~mask_ff & map_ok & ~take_oh &
      {NL{gen_ff && !err_w}};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pend_ff <= '0;
         busy_ff <= '0;
         err_ff <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
         busy_ff <= nxt_busy;
         err_ff <= err_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lowest line number is the lowest priority number
   always_comb begin
      found = 1'b0;
      win = '0;
      for (int i = NL - 1; i >= 0; i--) begin
         if (elig[i]) begin
            found = 1'b1;
            win = LW'(i);
         end
      end
   end

   // Request fields; priorities start above the timer levels
   wire [7:0] rel_off = {4'h0, win} - {4'h0, vec_ff.start_in};
   always_comb begin
      nxt_irq.valid = found;
      nxt_irq.prio = {1'b0, win} + PRIO_BASE;
      nxt_irq.line = win;
      nxt_irq.vector = vec_ff.reloc ? vec_ff.start_vec + rel_off : {4'h0, win};
      nxt_irq.seq = vec_ff.reloc ? vec_ff.start_si + rel_off : {4'h0, win};
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= '0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse capture: first filtered rise per scan, shown for the next scan
   wire [NL-1:0] cap_set = rise & pc_sel;
   // A rise in the scan-end cycle belongs to the next scan, so set wins
   wire [NL-1:0] nxt_latch = cap_set | (latch_ff & ~{NL{scan_end}});
   wire [NL-1:0] nxt_bits = scan_end ? (latch_ff & pc_sel) : bits_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         latch_ff <= '0;
         bits_ff <= '0;
      end else begin
         latch_ff <= nxt_latch;
         bits_ff <= nxt_bits;
      end
   end

   // Direct reads bypass the stretch, so they are flagged, not served
   wire unsup_set = direct_access && pc_sel[access_line];
   wire unsup_clr = wr_stat && wdata[ST_UNSUP];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         unsup_ff <= 1'b0;
      end else begin
         unsup_ff <= unsup_set || (unsup_ff && !unsup_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero
   wire [31:0] stat_w = {err_ff ? ERR_PARAM : 16'h0000, 14'h0000, unsup_ff, err_ff};
   wire [31:0] rd_val =
      (addr == A_CMD) ? {31'h0000_0000, gen_ff} :
      (addr == A_FUNC) ? func_ff :
      (addr == A_EDGE) ? edge_ff :
      (addr == A_MASK) ? {16'h0000, mask_ff} :
      (addr == A_RESP0) ? resp0_ff :
      (addr == A_RESP1) ? resp1_ff :
      (addr == A_VEC) ? vec_ff :
      (addr == A_STAT) ? stat_w :
      (addr == A_PEND) ? {busy_ff, pend_ff} :
      (addr == A_BITS) ? {16'h0000, bits_ff} :
      (addr == A_LVL) ? {16'h0000, lvl} : 32'h0000_0000;

   // Data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= rd ? rd_val : 32'h0000_0000;
      end
   end

   assign rdata = rdata_ff;
   assign irq = irq_ff;
   assign input_bits = bits_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   wire [NL-1:0] below_w = (NL'(1) << irq_ff.line) - NL'(1);
   // One-hot of the presented line, so $past never indexes with an old line
   wire [NL-1:0] line_oh = NL'(1) << irq_ff.line;
   // Capture bits that the coming scan end will show
   wire [NL-1:0] shown_w = latch_ff & pc_sel;

   sequence s_held;
      (busy_ff & pend_ff) != '0;
   endsequence
   sequence s_no_start;
      !took;
   endsequence
   sequence s_caught;
      scan_end && shown_w != '0;
   endsequence
   sequence s_shown;
      (bits_ff & $past(shown_w)) == $past(shown_w);
   endsequence

   pend_set_a: assert property (trig != '0 |=>
      (pend_ff & $past(trig)) == $past(trig))
      else $error("Trigger not held as pending");
   prio_map_a: assert property (irq_ff.valid |->
      irq_ff.prio == {1'b0, irq_ff.line} + PRIO_BASE &&
      ($past(vec_ff.reloc) || irq_ff.vector == {4'h0, irq_ff.line}))
      else $error("Default priority or vector wrong");
   prio_rsv_a: assert property (irq_ff.valid |-> irq_ff.prio > PRIO_TIMER_MAX)
      else $error("Line request on a timer level");
   reloc_vec_a: assert property (irq_ff.valid && $past(vec_ff.reloc) |->
      irq_ff.vector == $past(vec_ff.start_vec) + {4'h0, irq_ff.line} -
      {4'h0, $past(vec_ff.start_in)})
      else $error("Relocated vector wrong");
   param_err_a: assert property (err_ff |-> !irq_ff.valid &&
      stat_w[31:16] == ERR_PARAM)
      else $error("Request under parameter error");
   edge_sel_a: assert property ((pend_ff & ~$past(pend_ff) & ~$past(trig)) == '0)
      else $error("Pending without a selected edge");
   hold_one_a: assert property (s_held ##0 s_no_start |=>
      (pend_ff & $past(busy_ff & pend_ff & int_sel)) == $past(busy_ff & pend_ff & int_sel))
      else $error("Held trigger lost while routine ran");
   glob_off_a: assert property (!gen_ff || err_w |=> !irq_ff.valid)
      else $error("Request while locked out");
   mask_blk_a: assert property (irq_ff.valid |-> ($past(mask_ff) & line_oh) == '0)
      else $error("Masked routine requested");

   // Capture side, watched on every line at once, then lowest-first and function split
   cap_scan_a: assert property (s_caught |=> s_shown)
      else $error("Captured bit not shown for one scan");
   cap_stand_a: assert property (!scan_end |=> $stable(bits_ff))
      else $error("Capture bit moved inside a scan");
   cap_rise_a: assert property ((latch_ff & ~$past(latch_ff)) != '0 |->
      (latch_ff & ~$past(latch_ff) & ~$past(rise & pc_sel)) == '0)
      else $error("Capture without a filtered rise");
   cap_first_a: assert property (!scan_end |=>
      (latch_ff & $past(latch_ff)) == $past(latch_ff))
      else $error("Capture dropped inside a scan");
   cap_once_a: assert property (scan_end |=> (bits_ff & ~$past(latch_ff)) == '0)
      else $error("Bit kept on past its scan");
   lowest_a: assert property (irq_ff.valid |-> ($past(elig) & below_w) == '0)
      else $error("Lower priority number skipped");
   func_sel_a: assert property ((pend_ff & ~$past(int_sel)) == '0 &&
      (latch_ff & $past(int_sel)) == '0)
      else $error("Unselected function acted on a line");

   // Routine start, held triggers, relocation, default sequence and direct access
   take_busy_a: assert property (took |=> (busy_ff & $past(take_oh)) == $past(take_oh))
      else $error("Started routine not marked running");
   busy_blk_a: assert property (irq_ff.valid |-> ($past(busy_ff) & line_oh) == '0)
      else $error("Running routine requested again");
   irq_gone_a: assert property (took |=>
      !irq_ff.valid || irq_ff.line != $past(irq_ff.line))
      else $error("Started routine still presented");
   pend_keep_a: assert property (s_no_start |=>
      (pend_ff & $past(pend_ff & int_sel)) == $past(pend_ff & int_sel))
      else $error("Pending trigger dropped without a start");
   rng_blk_a: assert property (irq_ff.valid && $past(vec_ff.reloc) |->
      ($past(in_rng) & line_oh) != '0)
      else $error("Request outside the relocated range");
   seq_map_a: assert property (irq_ff.valid && !$past(vec_ff.reloc) |->
      irq_ff.seq == {4'h0, irq_ff.line})
      else $error("Default sequence number wrong");
   unsup_set_a: assert property (direct_access && pc_sel[access_line] |=> unsup_ff)
      else $error("Direct access on a capture line not flagged");
endmodule
`default_nettype wire

// [tb/ieipc_src.sv]
/*
 ieipc_src: switches and sensors on the sixteen input lines.
 Assumes the bench calls its tasks; a line keeps its level between calls.
*/
`timescale 1ns/1ps
`default_nettype none
module ieipc_src import ieipc_pkg::*; #(
   parameter int MIN_HOLD = 8
) (
   input wire logic clock,
   output logic [NL-1:0] ext_in
);
   // All lines open at power up
   initial ext_in = '0;

   ////////////////////////////////////////////////////////////////////////////
   // Move one line just after an edge; a switch stays where it was put
   task automatic set(input int l, input logic v);
      @(posedge clock);
      ext_in[l] <= v;
   endtask

   // Short holds are stretched, since the filter would swallow them
   task automatic drive(input int l, input logic v, input int cyc);
      set(l, v);
      repeat ((cyc < MIN_HOLD) ? MIN_HOLD : cyc) @(posedge clock);
   endtask

   // One on pulse followed by an equally long off time
   task automatic pulse(input int l);
      drive(l, 1'b1, MIN_HOLD);
      drive(l, 1'b0, MIN_HOLD);
   endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
 testbench: register, edge interrupt, capture and filter scenarios.
 Assumes ieipc_top with one clock per filter tick and the ieipc_src model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin failures++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module testbench import ieipc_pkg::*;;
   logic clock, rst_n, scan_end, irq_take, irq_end, direct_access, wr, rd;
   logic [LW-1:0] end_line, access_line;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, rv;
   logic [NL-1:0] ext_in, input_bits;
   ieipc_irq_s irq;
   int failures, total_checks, cycles;
   localparam logic [3:0] RISE = 4'h5; // Lines 0 and 2 take rising edges
   localparam logic [3:0] FALL = 4'h6; // Lines 1 and 2 take falling edges

   ieipc_src #(.MIN_HOLD(8)) src (.clock(clock), .ext_in(ext_in));
   ieipc_top #(.TICK_CYCLES(1)) dut (.clock(clock), .rst_n(rst_n), .ext_in(ext_in),
      .scan_end(scan_end), .irq_take(irq_take), .irq_end(irq_end), .end_line(end_line),
      .direct_access(direct_access), .access_line(access_line), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .input_bits(input_bits));

   // Free running clock; a hang is cut off well past the expected run
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Register port: strobes one cycle, read data only in the next cycle
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      rv = rdata;
   endtask
   task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] ex);
      rd_reg(a);
      `CHK(nm, ex, rv)
   endtask

   // Finish the routine of line l when go is set; a quiet pulse otherwise
   task automatic end_irq(input logic [3:0] l, input logic go);
      @(posedge clock);
      irq_end <= go;
      end_line <= l;
      @(posedge clock);
      irq_end <= 1'b0;
   endtask

   // Wait a bounded time for a request; if one shows, take it and maybe end it
   task automatic irq_check(input logic [3:0] l, input logic ex, input logic [7:0] vec,
      input logic fin);
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < 60 && !seen; n++) begin
         @(negedge clock);
         seen = (irq.valid === 1'b1);
      end
      `CHK("irq valid", ex, seen)
      if (seen) begin
         `CHK("irq line", l, irq.line)
         `CHK("irq vector", vec, irq.vector)
         `CHK("irq prio", PRIO_BASE + 5'(l), irq.prio)
         @(posedge clock);
         irq_take <= seen;
         @(posedge clock);
         irq_take <= 1'b0;
         end_irq(l, fin);
      end
   endtask

   // End of scan, then look at one capture bit once it has settled
   task automatic scan_chk(input int l, input logic ex);
      @(posedge clock);
      scan_end <= 1'b1;
      @(posedge clock);
      scan_end <= 1'b0;
      @(negedge clock);
      `CHK("capture bit", ex, input_bits[l])
   endtask
   task automatic touch(input logic [3:0] l);
      @(posedge clock);
      direct_access <= 1'b1;
      access_line <= l;
      @(posedge clock);
      direct_access <= 1'b0;
   endtask
   task automatic lvl_chk(input int l, input int w, input logic ex);
      repeat (w) @(posedge clock);
      rd_reg(A_LVL);
      `CHK("filtered level", ex, rv[l])
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      scan_end = 1'b0;
      irq_take = 1'b0;
      irq_end = 1'b0;
      direct_access = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      {end_line, access_line, addr, wdata, rv} = '0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      chk_reg("cmd reset", A_CMD, 32'h0);
      chk_reg("func reset", A_FUNC, RST_FUNC);
      chk_reg("edge reset", A_EDGE, RST_EDGE);
      chk_reg("vec reset", A_VEC, RST_VEC);
      chk_reg("unmapped", 8'h40, 32'h0);
      wr_reg(A_FUNC, 32'h0010_000F);
      wr_reg(A_EDGE, 32'h5555_5539);
      wr_reg(A_CMD, 32'h1);
      chk_reg("cmd unlocked", A_CMD, 32'h1);
      // Every edge condition on both edges of lines 0 to 3
      for (int l = 0; l < 4; l++) begin
         src.drive(l, 1'b1, 8);
         irq_check(4'(l), RISE[l], 8'(l), 1'b1);
         src.drive(l, 1'b0, 8);
         irq_check(4'(l), FALL[l], 8'(l), 1'b1);
      end
      // Lockout holds triggers; line 1 pends first yet line 0 goes first
      wr_reg(A_CMD, 32'h2);
      src.drive(1, 1'b1, 8);
      src.drive(1, 1'b0, 8);
      src.drive(0, 1'b1, 8);
      irq_check(4'h0, 1'b0, 8'h0, 1'b0);
      wr_reg(A_CMD, 32'h1);
      irq_check(4'h0, 1'b1, 8'h0, 1'b1);
      irq_check(4'h1, 1'b1, 8'h1, 1'b1);
      wr_reg(A_MASK, 32'h4);
      src.drive(2, 1'b1, 8);
      irq_check(4'h2, 1'b0, 8'h2, 1'b0);
      wr_reg(A_MASK, 32'h0);
      irq_check(4'h2, 1'b1, 8'h2, 1'b1);
      // Three edges while the routine runs: one held, two dropped
      src.drive(2, 1'b0, 8);
      irq_check(4'h2, 1'b1, 8'h2, 1'b0);
      src.drive(2, 1'b1, 8);
      src.drive(2, 1'b0, 8);
      src.drive(2, 1'b1, 8);
      end_irq(4'h2, 1'b1);
      irq_check(4'h2, 1'b1, 8'h2, 1'b1);
      irq_check(4'h2, 1'b0, 8'h2, 1'b0);
      // Relocated range of lines 0 and 1 from vector 0x32, SI 0x10
      wr_reg(A_VEC, 32'h8100_0232);
      wr_reg(A_FUNC, 32'h0010_000C);
      chk_reg("param error", A_STAT, {ERR_PARAM, 16'h0001});
      wr_reg(A_FUNC, 32'h0010_0003);
      chk_reg("param ok", A_STAT, 32'h0);
      src.drive(1, 1'b1, 8);
      src.drive(1, 1'b0, 8);
      repeat (10) @(posedge clock);
      @(negedge clock);
      `CHK("irq seq", 8'h11, irq.seq)
      irq_check(4'h1, 1'b1, 8'h33, 1'b1);
      wr_reg(A_VEC, 32'h0);
      // Pulse capture on line 4
      scan_chk(4, 1'b0);
      src.pulse(4);
      src.pulse(4);
      scan_chk(4, 1'b1);
      scan_chk(4, 1'b0);
      src.pulse(4);
      scan_chk(4, 1'b1);
      src.pulse(4);
      scan_chk(4, 1'b1);
      scan_chk(4, 1'b0);
      src.drive(4, 1'b1, 8);
      scan_chk(4, 1'b1);
      scan_chk(4, 1'b0);
      src.drive(4, 1'b0, 8);
      scan_chk(4, 1'b0);
      // Functions stay apart on capture and interrupt lines
      src.pulse(4);
      irq_check(4'h4, 1'b0, 8'h4, 1'b0);
      src.drive(0, 1'b0, 8);
      src.drive(0, 1'b1, 8);
      irq_check(4'h0, 1'b1, 8'h0, 1'b1);
      scan_chk(0, 1'b0);
      `CHK("capture kept", 1'b1, input_bits[4])
      touch(4'h0);
      chk_reg("no unsup", A_STAT, 32'h0);
      touch(4'h4);
      chk_reg("unsup flag", A_STAT, 32'h2);
      wr_reg(A_STAT, 32'h2);
      chk_reg("unsup clear", A_STAT, 32'h0);
      // 0.1 ms on a fast and a standard line; only standard off lasts 0.2 ms
      wr_reg(A_RESP0, 32'h0010_0000);
      for (int l = 5; l < 7; l++) begin
         src.set(l, 1'b1);
         lvl_chk(l, 5, 1'b0);
         lvl_chk(l, 20, 1'b1);
         src.set(l, 1'b0);
         lvl_chk(l, 14, l == 6);
         lvl_chk(l, 20, 1'b0);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
